// >>> hw/serial_ctrl.sv
// Functional notes
// - Control register is 8 bits, read/write, zero after reset.
// - Control bits 1 and 0 always read back as zero.
// - Bit 7 gates the holding-empty transmit request.
// - Holding-empty request drops on read-then-clear of its flag or enable cleared.
// - Bit 6 gates both receive-full and receive-error requests.
// - Receive requests drop when causing flag cleared or bit 6 cleared.
// - With transmitter off, holding-empty flag is forced to one.
// - Transmitter on: clearing holding-empty flag after a data write starts sending.
// - Turning receiver off leaves the receive flags unchanged.
// - Receiver on: reception starts on start bit or incoming serial clock.
// - Address filter bit acts only when address mode is selected.
// - Filtering discards unmarked characters: no transfer, no flags, no requests.
// - Marked character sets mark bit, clears filter bit, resumes normal flagging.
// - Bit 2 gates the done request when last bit leaves with holding empty.
// - Done request drops on holding-empty and finished flags cleared, or bit 2 cleared.
// - Holding-empty set by reset, transmitter off, or holding-to-shift move.
// - Status flags other than the mark bit take only a written zero, after having been read as one.
// - Address mode makes parity enable ignored; polarity still drives parity_odd.
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_defines.svh"
module serial_ctrl
	import serial_ctrl_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Transmit engine events (same clock)
	input wire logic tx_load,
	input wire logic tx_last_bit,
	// Receive engine events (same clock)
	input wire logic rx_char_done,
	input wire logic rx_stop_bad,
	input wire logic rx_parity_bad,
	input wire logic rx_mark_in,
	// Engine controls
	output logic tx_go,
	output logic rx_active,
	output logic rx_transfer,
	output logic parity_check_en,
	output logic parity_odd,
	// Interrupt requests
	output logic tx_empty_irq,
	output logic rx_full_irq,
	output logic rx_error_irq,
	output logic tx_done_irq
);
	bus_state_t bus_r, bus_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] fmt_r, fmt_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic addr_mark_r, addr_mark_nxt;
	logic acc, wr_ctrl, wr_flags, wr_fmt, rd_flags;
	logic tx_empty, rx_full, ovr, ferr, perr, tx_fin;
	logic filtering, accept, char_ok, holding_write;
	logic [7:0] flags;
	logic [7:0] wbyte;

	assign wbyte = avs_writedata[7:0];
	// One wait state: request taken in IDLE, answered with waitrequest low in ACK
	assign acc = (avs_read || avs_write) && (bus_r == BUS_IDLE);
	assign avs_waitrequest = (avs_read || avs_write) && (bus_r != BUS_ACK);
	assign wr_ctrl = acc && avs_write && avs_byteenable[0] && avs_address == `OFF_CTRL;
	assign wr_flags = acc && avs_write && avs_byteenable[0] && avs_address == `OFF_FLAGS;
	assign wr_fmt = acc && avs_write && avs_byteenable[0] && avs_address == `OFF_FORMAT;
	assign rd_flags = acc && avs_read && avs_address == `OFF_FLAGS;

	// Filter applies only in address mode
	assign filtering = fmt_r[`FMT_ADDR_MODE] && ctrl_r[`CTRL_ADDR_FILTER_IRQ_EN];
	// Overrun and framing errors block further reception until cleared
	assign accept = ctrl_r[`CTRL_RX_ON] && rx_char_done && !(filtering && !rx_mark_in);
	assign char_ok = accept && !ovr && !ferr;
	assign rx_transfer = char_ok && !rx_full && !rx_stop_bad;
	assign rx_active = ctrl_r[`CTRL_RX_ON];
	assign parity_check_en = fmt_r[`FMT_PARITY_EN] && !fmt_r[`FMT_ADDR_MODE];
	assign parity_odd = fmt_r[`FMT_PARITY_ODD];
	assign tx_go = ctrl_r[`CTRL_TX_ON] && !tx_empty;
	assign holding_write = wr_flags && !wbyte[`FLG_TX_HOLDING_EMPTY];

	always_comb begin
		bus_nxt = bus_r;
		case (bus_r)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_nxt = BUS_ACK;
				end
			end
			BUS_ACK: begin
				bus_nxt = BUS_IDLE;
			end
			default: begin
				bus_nxt = BUS_IDLE;
			end
		endcase
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		fmt_nxt = fmt_r;
		addr_mark_nxt = addr_mark_r;
		if (wr_ctrl) begin
			ctrl_nxt = wbyte & `CTRL_WRITABLE;
		end
		if (wr_fmt) begin
			fmt_nxt = wbyte & `FORMAT_WRITABLE;
		end
		if (accept && fmt_r[`FMT_ADDR_MODE]) begin
			addr_mark_nxt = rx_mark_in;
			if (rx_mark_in) begin
				ctrl_nxt[`CTRL_ADDR_FILTER_IRQ_EN] = 1'b0;
			end
		end
	end

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (acc && avs_read) begin
			case (avs_address)
				`OFF_CTRL: rdata_nxt = {24'h00_0000, ctrl_r[7:2], 2'b00};
				`OFF_FLAGS: rdata_nxt = {24'h00_0000, flags};
				`OFF_FORMAT: rdata_nxt = {24'h00_0000, fmt_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end else if (bus_r == BUS_ACK) begin
			rdata_nxt = rdata_r;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_r <= BUS_IDLE;
			ctrl_r <= `CTRL_RESET;
			fmt_r <= `FORMAT_RESET;
			rdata_r <= 32'h0000_0000;
			addr_mark_r <= 1'b0;
		end else if (ce) begin
			bus_r <= bus_nxt;
			ctrl_r <= ctrl_nxt;
			fmt_r <= fmt_nxt;
			rdata_r <= rdata_nxt;
			addr_mark_r <= addr_mark_nxt;
		end
	end

	assign avs_readdata = rdata_r;

	// Flags keep their value while the receiver is off; only hardware events and transmitter-off (holding-empty) set them
	flag_cell #(.RESET_VAL(1'b1)) u_tx_empty (
		.clk(clk), .rstn(rstn), .ce(ce),
		.set_i(tx_load),
		.force_set(!ctrl_r[`CTRL_TX_ON]),
		.read_seen(rd_flags),
		.clear_req(holding_write),
		.q(tx_empty)
	);
	flag_cell #(.RESET_VAL(1'b0)) u_rx_full (
		.clk(clk), .rstn(rstn), .ce(ce),
		.set_i(rx_transfer),
		.force_set(1'b0),
		.read_seen(rd_flags),
		.clear_req(wr_flags && !wbyte[`FLG_RX_HOLDING_FULL]),
		.q(rx_full)
	);
	flag_cell #(.RESET_VAL(1'b0)) u_overrun (
		.clk(clk), .rstn(rstn), .ce(ce),
		.set_i(char_ok && rx_full),
		.force_set(1'b0),
		.read_seen(rd_flags),
		.clear_req(wr_flags && !wbyte[`FLG_OVERRUN]),
		.q(ovr)
	);
	flag_cell #(.RESET_VAL(1'b0)) u_frame (
		.clk(clk), .rstn(rstn), .ce(ce),
		.set_i(char_ok && rx_stop_bad),
		.force_set(1'b0),
		.read_seen(rd_flags),
		.clear_req(wr_flags && !wbyte[`FLG_FRAME_ERR]),
		.q(ferr)
	);
	flag_cell #(.RESET_VAL(1'b0)) u_parity (
		.clk(clk), .rstn(rstn), .ce(ce),
		.set_i(char_ok && rx_parity_bad && parity_check_en),
		.force_set(1'b0),
		.read_seen(rd_flags),
		.clear_req(wr_flags && !wbyte[`FLG_PARITY_ERR]),
		.q(perr)
	);
	// Finished flag clears together with a holding-empty clear
	flag_cell #(.RESET_VAL(1'b1)) u_tx_fin (
		.clk(clk), .rstn(rstn), .ce(ce),
		.set_i(tx_last_bit && tx_empty),
		.force_set(1'b0),
		.read_seen(rd_flags),
		.clear_req(holding_write),
		.q(tx_fin)
	);

	assign flags = {tx_empty, rx_full, ovr, ferr, perr, tx_fin, addr_mark_r, 1'b0};

	// Requests are plain levels so clearing a flag or enable drops them at once
	assign tx_empty_irq = ctrl_r[`CTRL_TX_EMPTY_IRQ_EN] && tx_empty;
	assign rx_full_irq = ctrl_r[`CTRL_RX_IRQ_EN] && rx_full;
	assign rx_error_irq = ctrl_r[`CTRL_RX_IRQ_EN] && (ovr || ferr || perr);
	assign tx_done_irq = ctrl_r[`CTRL_TX_DONE_IRQ_EN] && tx_fin;
endmodule
`default_nettype wire

// >>> hw/serial_ctrl_defines.svh
`ifndef SERIAL_CTRL_DEFINES_SVH
`define SERIAL_CTRL_DEFINES_SVH

// Register word offsets (byte addresses on the bus)
`define OFF_CTRL 4'h0
`define OFF_FLAGS 4'h4
`define OFF_FORMAT 4'h8

// Control register fields
`define CTRL_TX_EMPTY_IRQ_EN 7
`define CTRL_RX_IRQ_EN 6
`define CTRL_TX_ON 5
`define CTRL_RX_ON 4
`define CTRL_ADDR_FILTER_IRQ_EN 3
`define CTRL_TX_DONE_IRQ_EN 2
`define CTRL_WRITABLE 8'hfc
`define CTRL_RESET 8'h00

// Flags register fields
`define FLG_TX_HOLDING_EMPTY 7
`define FLG_RX_HOLDING_FULL 6
`define FLG_OVERRUN 5
`define FLG_FRAME_ERR 4
`define FLG_PARITY_ERR 3
`define FLG_TX_FINISHED 2
`define FLG_ADDR_MARK 1
`define FLAGS_RESET 8'h84

// Format register fields
`define FMT_PARITY_EN 5
`define FMT_PARITY_ODD 4
`define FMT_ADDR_MODE 2
`define FORMAT_WRITABLE 8'h7f
`define FORMAT_RESET 8'h00

`endif

// >>> hw/serial_ctrl_pkg.sv
package serial_ctrl_pkg;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage

// >>> hw/flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
// Status flag: hardware set wins; software may only clear after reading it as 1
module flag_cell #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Events
	input wire logic set_i,
	input wire logic force_set,
	input wire logic read_seen,
	input wire logic clear_req,
	// State
	output logic q
);
	logic q_r;
	logic q_nxt;
	logic armed_r;
	logic armed_nxt;

	always_comb begin
		q_nxt = q_r;
		armed_nxt = armed_r;
		if (read_seen && q_r) begin
			armed_nxt = 1'b1;
		end
		if (clear_req && armed_r) begin
			q_nxt = 1'b0;
			armed_nxt = 1'b0;
		end
		if (set_i || force_set) begin
			q_nxt = 1'b1;
			armed_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q_r <= RESET_VAL;
			armed_r <= 1'b0;
		end else if (ce) begin
			q_r <= q_nxt;
			armed_r <= armed_nxt;
		end
	end

	assign q = q_r;
endmodule
`default_nettype wire

// >>> tb/serial_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Engine and requests
	input wire logic tx_go,
	input wire logic tx_load,
	input wire logic rx_active,
	input wire logic rx_transfer,
	input wire logic rx_char_done,
	input wire logic tx_empty_irq,
	input wire logic rx_full_irq,
	input wire logic rx_error_irq,
	input wire logic tx_done_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Control write taken at this edge
	wire logic wc = ce && avs_write && avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
	tx_irq_off_a: assert property (wc && !avs_writedata[7] |=> !tx_empty_irq)
		else $error("tx empty irq kept");
	rx_irq_off_a: assert property (wc && !avs_writedata[6] |=> !rx_full_irq && !rx_error_irq)
		else $error("rx irq kept");
	done_irq_off_a: assert property (wc && !avs_writedata[2] |=> !tx_done_irq)
		else $error("done irq kept");
	tx_off_a: assert property (wc && !avs_writedata[5] |=> !tx_go)
		else $error("tx_go with tx off");
	rx_on_a: assert property (wc |=> rx_active == $past(avs_writedata[4]))
		else $error("rx_active wrong");
	reserved_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
		|-> avs_readdata[1:0] == 2'b00 && avs_readdata[31:8] == 24'h0)
		else $error("reserved bits set");
	load_empty_a: assert property (ce && tx_load |=> !tx_go)
		else $error("tx_go after load");
	xfer_cause_a: assert property (rx_transfer |-> rx_char_done)
		else $error("transfer without char");
	cover property (tx_done_irq);
	cover property (rx_error_irq);
	cover property (rx_full_irq);
endmodule
`default_nettype wire

// >>> tb/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Transmit engine stand-in; dly sets how promptly it loads
module serial_peer (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Device side
	input wire logic tx_go,
	input wire logic [2:0] dly,
	output logic tx_load,
	output logic tx_last_bit
);
	logic [3:0] cnt_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cnt_r <= 4'h0;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r + 4'h1;
		else if (tx_go)
			cnt_r <= {1'b0, dly} + 4'h1;
	end
	assign tx_load = cnt_r == 4'h9;
	assign tx_last_bit = cnt_r == 4'hf;
endmodule
`default_nettype wire

// >>> tb/serial_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic rx_char_done = 1'b0;
	logic rx_stop_bad = 1'b0;
	logic rx_parity_bad = 1'b0;
	logic rx_mark_in = 1'b0;
	logic [2:0] dly = 3'h0;
	logic ce = 1'b1;
	logic [3:0] be = 4'hf;
	logic [31:0] avs_readdata, q;
	logic [7:0] d;
	logic avs_waitrequest, tx_go, tx_load, tx_last_bit, rx_active, pce;
	logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
	integer seed = 32'h254e;
	integer bad_count = 0;
	integer n_compared = 0;
	integer i;
	always #5 clk = ~clk;
	serial_ctrl i_dut (.clk, .rstn, .ce(ce), .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .tx_load,
		.tx_last_bit, .rx_char_done, .rx_stop_bad, .rx_parity_bad, .rx_mark_in, .tx_go,
		.rx_active, .rx_transfer(), .parity_check_en(pce), .parity_odd(), .tx_empty_irq,
		.rx_full_irq, .rx_error_irq, .tx_done_irq);
	serial_peer i_peer (.clk, .rstn, .tx_go, .dly, .tx_load, .tx_last_bit);
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Waitrequest and read data are sampled at the rising edge, ahead of its updates
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, v};
		avs_write <= wr;
		avs_read <= !wr;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata;
		if (i >= 50) begin
			bad_count++;
			conclude;
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task rxc(input logic m, input logic sb, input logic pb);
		@(posedge clk);
		rx_char_done <= 1'b1;
		rx_mark_in <= m;
		rx_stop_bad <= sb;
		rx_parity_bad <= pb;
		@(posedge clk);
		rx_char_done <= 1'b0;
		@(negedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		bus(0, 4'h0, 8'h0);
		check("ctrl", q, 32'h0);
		bus(0, 4'h4, 8'h0);
		check("flags", q, 32'h84);
		bus(0, 4'hc, 8'h0);
		check("unmapped", q, 32'h0);
		bus(1, 4'h8, 8'h00);
		for (int k = 0; k < 10; k++) begin
			d = (k == 0) ? 8'hfc : 8'($random(seed)) & 8'hfc;
			bus(1, 4'h0, d);
			check("empty irq", tx_empty_irq, d[7]);
			check("done irq", tx_done_irq, d[2]);
			bus(0, 4'h0, 8'h0);
			check("ctrl rd", q, {24'h0, d & 8'hfc});
		end
		be <= 4'he;
		bus(1, 4'h0, 8'h00);
		be <= 4'hf;
		bus(0, 4'h0, 8'h0);
		check("lane off", q, {24'h0, d});
		$display("register test done");
		dly <= 3'($random(seed));
		bus(1, 4'h0, 8'ha4);
		bus(0, 4'h4, 8'h0);
		bus(1, 4'h4, 8'h00);
		check("empty clr", {tx_empty_irq, tx_go}, 2'b01);
		i = 0;
		while (tx_done_irq !== 1'b1 && i < 100) begin
			@(negedge clk);
			i++;
		end
		check("done set", tx_done_irq, 1'b1);
		if (i >= 100)
			conclude;
		check("empty set", tx_empty_irq, 1'b1);
		bus(1, 4'h4, 8'h00);
		check("unread clr", tx_done_irq, 1'b1);
		bus(0, 4'h4, 8'h0);
		check("flags tx", q, 32'h84);
		bus(1, 4'h4, 8'h00);
		check("done clr", tx_done_irq, 1'b0);
		bus(1, 4'h0, 8'h00);
		bus(0, 4'h4, 8'h0);
		check("empty locked", q[7], 1'b1);
		$display("transmit test done");
		bus(1, 4'h0, 8'h50);
		ce <= 1'b0;
		rxc(0, 0, 0);
		check("frozen", rx_full_irq, 1'b0);
		@(posedge clk);
		ce <= 1'b1;
		rxc(0, 0, 0);
		check("full irq", rx_full_irq, 1'b1);
		bus(1, 4'h0, 8'h10);
		check("full off", rx_full_irq, 1'b0);
		bus(1, 4'h0, 8'h00);
		bus(0, 4'h4, 8'h0);
		check("full kept", q[6], 1'b1);
		bus(1, 4'h4, 8'h00);
		bus(1, 4'h8, 8'h34);
		check("parity off", pce, 1'b0);
		bus(1, 4'h0, 8'h58);
		rxc(0, 1, 1);
		check("filtered", {rx_full_irq, rx_error_irq}, 2'b00);
		rxc(1, 1, 0);
		check("marked err", rx_error_irq, 1'b1);
		bus(0, 4'h0, 8'h0);
		check("filter clr", q, 32'h50);
		bus(0, 4'h4, 8'h0);
		bus(1, 4'h4, 8'h00);
		check("err clr", rx_error_irq, 1'b0);
		bus(1, 4'h0, 8'h00);
		bus(1, 4'h8, 8'h30);
		check("parity on", pce, 1'b1);
		bus(1, 4'h0, 8'h58);
		rxc(0, 0, 0);
		check("no filter", rx_full_irq, 1'b1);
		$display("receive test done");
		conclude;
	end
endmodule
bind serial_ctrl serial_ctrl_sva i_sva (.clk, .rstn, .ce, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_go, .tx_load, .rx_active,
	.rx_transfer, .rx_char_done, .tx_empty_irq, .rx_full_irq, .rx_error_irq, .tx_done_irq);
`default_nettype wire
